//--- design/ppmc_pkg.sv
// Constants and types of the power-management capability register block.
// Notes on behaviour
// - Next-pointer byte always reads zero.
// - Capabilities word at A2h, resets to FE11h.
// - Bit 15 writable, resets to one.
// - Bits 14..11 read one, ignore writes.
// - Bit 10 reads one: D2 supported.
// - Bit 9 reads one: D1 supported.
// - Bits 8..6 reserved, read zero.
// - Bit 5 reads zero: no special init.
// - Bit 4 follows bit 15.
// - Bit 3 reads zero: no bus clock needed.
// - Bits 2..0 read version 001b.
// - Bit 15 restore on bus reset depends on wake enable; global reset always restores it.
// - Capability identifier byte reads 01h.
// - Wake enable is writable control bit 8.
package ppmc_pkg;
  localparam logic [7:0]  OFS_CAP_ID        = 8'hA0;
  localparam logic [7:0]  OFS_NEXT_PTR      = 8'hA1;
  localparam logic [7:0]  OFS_PM_CAPS       = 8'hA2;
  localparam logic [7:0]  OFS_PM_CTRL       = 8'hA4;
  localparam logic [7:0]  CAP_ID_VAL        = 8'h01;
  localparam logic [7:0]  NEXT_PTR_VAL      = 8'h00;
  localparam logic [15:0] PM_CAPS_RST       = 16'hFE11;
  localparam logic [3:0]  WAKE_STATES_VAL   = 4'hF;
  localparam logic [2:0]  PM_VERSION_VAL    = 3'h1;
  localparam int          CAPS_COLD_BIT     = 15;
  localparam int          CAPS_WAKE_LSB     = 11;
  localparam int          CAPS_D2_BIT       = 10;
  localparam int          CAPS_D1_BIT       = 9;
  localparam int          CAPS_AUX_BIT      = 4;
  localparam int          CAPS_CLK_BIT      = 3;
  localparam int          CTRL_WAKE_EN_BIT  = 8;
  localparam logic        COLD_WAKE_RST     = 1'h1;
  localparam logic        WAKE_EN_RST       = 1'h0;
endpackage : ppmc_pkg

//--- design/ppmc_rd_if.sv
// Carrier between the register core and its read-data assembler.
`timescale 1ns/100ps
interface ppmc_rd_if;
  logic        rd_stb;
  logic [5:0]  dw_addr;
  logic        cold_wake;
  logic        wake_en;
  logic [31:0] rdata;
  modport core (output rd_stb, dw_addr, cold_wake, wake_en, input rdata);
  modport mux  (input rd_stb, dw_addr, cold_wake, wake_en, output rdata);
endinterface : ppmc_rd_if

//--- design/ppmc_sync.sv
// Two-stage synchroniser for the reset pins.
`timescale 1ns/100ps
module ppmc_sync
  import ppmc_pkg::*;
(
  input  wire logic       clk,     // Core clock.
  input  wire logic       rst_b,   // Asynchronous reset, active low.
  input  wire logic [1:0] pin_in,  // Asynchronous pin levels.
  output logic      [1:0] pin_out  // Levels after two flip-flops.
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ppmc_sync_t;

  ppmc_sync_t st_q;
  ppmc_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_out = st_q.s2;
endmodule : ppmc_sync

//--- design/ppmc_rdmux.sv
// Read-data assembler: builds the addressed doubleword into a register.
`timescale 1ns/100ps
module ppmc_rdmux
  import ppmc_pkg::*;
(
  input  wire logic clk,   // Core clock.
  input  wire logic rst_b, // Asynchronous reset, active low.
  ppmc_rd_if.mux    rif    // Read request and register state.
);
  typedef struct packed {
    logic [31:0] rdata;
  } ppmc_rdmux_t;

  ppmc_rdmux_t st_q;
  ppmc_rdmux_t st_d;
  logic [15:0] caps;
  logic [31:0] ctrl;

  always_comb begin
    caps                           = '0;
    caps[CAPS_COLD_BIT]            = rif.cold_wake;
    caps[CAPS_WAKE_LSB+3:CAPS_WAKE_LSB] = WAKE_STATES_VAL;
    caps[CAPS_D2_BIT]              = 1'h1;
    caps[CAPS_D1_BIT]              = 1'h1;
    caps[CAPS_AUX_BIT]             = rif.cold_wake;
    caps[2:0]                      = PM_VERSION_VAL;
    ctrl                           = '0;
    ctrl[CTRL_WAKE_EN_BIT]         = rif.wake_en;
    st_d                           = '0;
    if (rif.rd_stb) begin
      // The whole doubleword is returned; the master picks its byte lanes.
      if (rif.dw_addr == OFS_CAP_ID[7:2]) begin
        st_d.rdata = {caps, NEXT_PTR_VAL, CAP_ID_VAL};
      end else if (rif.dw_addr == OFS_PM_CTRL[7:2]) begin
        st_d.rdata = ctrl;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rif.rdata = st_q.rdata;
endmodule : ppmc_rdmux

//--- design/ppmc_regs.sv
// Power-management capability registers with wake-aware bit 15 restore.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ppmc_regs
  import ppmc_pkg::*;
(
  input  wire logic        clk,             // Core clock, 250 MHz.
  input  wire logic        rst_b,           // Asynchronous reset, active low.
  input  wire logic        global_reset_in, // Global reset pin, active high.
  input  wire logic        bus_reset_in,    // Bus reset pin, active high.
  input  wire logic [7:0]  addr,            // Byte address, low two bits ignored.
  input  wire logic [31:0] wdata,           // Write data.
  input  wire logic [3:0]  byte_en,         // Write byte enables.
  input  wire logic        wr_stb,          // Write strobe.
  input  wire logic        rd_stb,          // Read strobe.
  output logic      [31:0] rdata,           // Read data, cycle after rd_stb.
  output logic             cold_wake,       // Cold-state wake advertised.
  output logic             wake_en          // Wake signalling enabled.
);
  typedef struct packed {
    logic cold_wake;
    logic wake_en;
  } ppmc_regs_t;

  ppmc_regs_t  st_q;
  ppmc_regs_t  st_d;
  logic [1:0]  rst_sync;
  logic        glob_rst;
  logic        brst;
  logic [5:0]  dw_addr;
  logic        cap_wr;
  logic        ctrl_wr;

  ppmc_rd_if rif ();

  // Reset pins are asynchronous to clk and are synchronised first.
  ppmc_sync ppmc_sync_inst (
    .clk     (clk),
    .rst_b   (rst_b),
    .pin_in  ({bus_reset_in, global_reset_in}),
    .pin_out (rst_sync)
  );

  ppmc_rdmux ppmc_rdmux_inst (
    .clk   (clk),
    .rst_b (rst_b),
    .rif   (rif)
  );

  assign glob_rst = rst_sync[0];
  assign brst    = rst_sync[1];
  assign dw_addr = addr[7:2];
  assign cap_wr  = wr_stb && (dw_addr == OFS_PM_CAPS[7:2]) && byte_en[3];
  assign ctrl_wr = wr_stb && (dw_addr == OFS_PM_CTRL[7:2]) && byte_en[1];

  always_comb begin
    st_d = st_q;
    // Only the top byte lane of the capabilities word holds a writable bit.
    if (cap_wr) begin
      st_d.cold_wake = wdata[16+CAPS_COLD_BIT];
    end
    if (ctrl_wr) begin
      st_d.wake_en = wdata[CTRL_WAKE_EN_BIT];
    end
    // With wake enabled the bus reset must not erase the wake context.
    if (brst && !st_q.wake_en) begin
      st_d.cold_wake = COLD_WAKE_RST;
    end
    if (glob_rst) begin
      st_d.cold_wake = COLD_WAKE_RST;
      st_d.wake_en   = WAKE_EN_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{cold_wake: COLD_WAKE_RST, wake_en: WAKE_EN_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign rif.rd_stb    = rd_stb;
  assign rif.dw_addr   = dw_addr;
  assign rif.cold_wake = st_q.cold_wake;
  assign rif.wake_en   = st_q.wake_en;
  assign rdata         = rif.rdata;
  assign cold_wake     = st_q.cold_wake;
  assign wake_en       = st_q.wake_en;

  // Checks below watch the registered read data against the state it came from, and the write and reset updates of bit 15 and wake enable.
  logic cap_rd;
  logic ctl_rd;
  logic oth_rd;
  assign cap_rd = rd_stb && (dw_addr == OFS_CAP_ID[7:2]);
  assign ctl_rd = rd_stb && (dw_addr == OFS_PM_CTRL[7:2]);
  assign oth_rd = rd_stb && !cap_rd && !ctl_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_next_ptr_zero: assert property (
    cap_rd |=> rdata[15:8] == NEXT_PTR_VAL)
    else $error("Next pointer byte is not zero.");

  chk_caps_reset_word: assert property (
    cap_rd && st_q.cold_wake |=> rdata[31:16] == PM_CAPS_RST)
    else $error("Capabilities word differs from its reset value.");

  chk_cold_write: assert property (
    cap_wr && !glob_rst && !(brst && !st_q.wake_en)
      |=> st_q.cold_wake == $past(wdata[31]))
    else $error("Cold wake bit did not take the written value.");

  chk_wake_states: assert property (
    cap_rd |=> rdata[30:27] == WAKE_STATES_VAL)
    else $error("Wake state bits are not all one.");

  chk_d2_state_supported: assert property (
    cap_rd |=> rdata[16+CAPS_D2_BIT])
    else $error("D2_state_supported bit reads zero.");

  chk_d1_state_supported: assert property (
    cap_rd |=> rdata[16+CAPS_D1_BIT])
    else $error("D1_state_supported bit reads zero.");

  chk_reserved_zero: assert property (
    cap_rd |=> rdata[24:22] == 3'h0)
    else $error("Reserved capability bits are not zero.");

  chk_no_init_bit: assert property (
    cap_rd |=> !rdata[21])
    else $error("Device specific init bit reads one.");

  chk_aux_follow: assert property (
    cap_rd |=> rdata[16+CAPS_AUX_BIT] == rdata[31]
               && rdata[31] == $past(st_q.cold_wake))
    else $error("Auxiliary power bit does not follow bit 15.");

  chk_bus_clock: assert property (
    cap_rd |=> !rdata[16+CAPS_CLK_BIT])
    else $error("Bus clock bit reads one.");

  chk_version_val: assert property (
    cap_rd |=> rdata[18:16] == PM_VERSION_VAL)
    else $error("Version field is wrong.");

  chk_global_restore: assert property (
    $rose(global_reset_in) ##2 1'h1 |=> st_q.cold_wake && !st_q.wake_en)
    else $error("Global reset did not restore bit 15.");

  chk_bus_hold: assert property (
    brst && !glob_rst && st_q.wake_en && !cap_wr |=> $stable(st_q.cold_wake))
    else $error("Bus reset altered bit 15 while wake enabled.");

  chk_bus_restore: assert property (
    brst && !st_q.wake_en |=> st_q.cold_wake)
    else $error("Bus reset did not restore bit 15.");

  chk_cap_id_byte: assert property (
    cap_rd |=> rdata[7:0] == CAP_ID_VAL)
    else $error("Capability identifier is wrong.");

  chk_wake_en_read: assert property (
    ctl_rd |=> rdata[CTRL_WAKE_EN_BIT] == $past(st_q.wake_en)
               && (rdata & ~(32'h1 << CTRL_WAKE_EN_BIT)) == 32'h0)
    else $error("Wake enable read back is wrong.");

  chk_ro_ignored: assert property (
    wr_stb && !cap_wr && !glob_rst && !brst |=> $stable(st_q.cold_wake))
    else $error("Bit 15 changed without a write to it.");

  chk_unmapped_zero: assert property (
    oth_rd ##1 !rd_stb |-> rdata == 32'h0 ##1 rdata == 32'h0)
    else $error("Unmapped or idle read data are not zero.");

  cov_cap_read: cover property (
    cap_rd ##1 rdata[31:16] == PM_CAPS_RST);

  cov_cold_clear: cover property (
    cap_wr && !wdata[31] ##1 !st_q.cold_wake ##1 cap_rd);

  cov_bus_hold: cover property (
    !st_q.cold_wake && st_q.wake_en && brst ##1 !st_q.cold_wake);

  cov_global: cover property (
    !st_q.cold_wake ##1 glob_rst ##1 st_q.cold_wake);
endmodule : ppmc_regs

//--- tb/pci_pm_capability_regs_tb.sv
// Self-checking testbench of the power-management capability register block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module pci_pm_capability_regs_tb;
  import ppmc_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        global_reset_in;
  logic        bus_reset_in;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  byte_en;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic        cold_wake;
  logic        wake_en;
  int          n_mismatch;
  int          checks_done;
  int          cycles;
  ppmc_regs ppmc_regs_inst (.clk(clk), .rst_b(rst_b), .global_reset_in(global_reset_in),
    .bus_reset_in(bus_reset_in), .addr(addr), .wdata(wdata), .byte_en(byte_en),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cold_wake(cold_wake),
    .wake_en(wake_en));
  always #2 clk = ~clk;
  // Expected A0h doubleword, derived bit by bit so that a wrong constant shows up.
  function automatic logic [31:0] exp_dw(input logic cold);
    return {cold, 4'hF, 1'h1, 1'h1, 3'h0, 1'h0, cold, 1'h0, 3'h1, 8'h00, 8'h01};
  endfunction : exp_dw
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    addr    <= a;
    wdata   <= d;
    byte_en <= be;
    wr_stb  <= 1'h1;
    @(posedge clk);
    wr_stb  <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1;
    `CHK("rdata", e, rdata)
    @(posedge clk);
    #1;
    `CHK("rdata idle", 32'h0, rdata)
  endtask : rd
  task automatic pulse_pin(input logic glob);
    @(posedge clk);
    if (glob) global_reset_in <= 1'h1;
    else bus_reset_in <= 1'h1;
    @(posedge clk);
    global_reset_in <= 1'h0;
    bus_reset_in    <= 1'h0;
    repeat (5) @(posedge clk);
    #1;
  endtask : pulse_pin
  task automatic t_reset_values;
    `CHK("cold_wake", COLD_WAKE_RST, cold_wake)
    `CHK("wake_en", WAKE_EN_RST, wake_en)
    rd(8'hA0, {PM_CAPS_RST, 8'h00, 8'h01});
    rd(8'hA3, exp_dw(1'h1));
  endtask : t_reset_values
  task automatic t_write_mask;
    wr(8'hA0, 32'h7FFFFFFF, 4'hF);
    rd(8'hA0, exp_dw(1'h0));
    `CHK("cold_wake", 1'h0, cold_wake)
    wr(8'hA0, 32'hFFFFFFFF, 4'h7);
    rd(8'hA0, exp_dw(1'h0));
    wr(8'hA0, 32'h80000000, 4'hF);
    rd(8'hA0, exp_dw(1'h1));
    wr(8'hA1, 32'h81FF0000, 4'hF);
    rd(8'hA2, exp_dw(1'h1));
  endtask : t_write_mask
  task automatic t_back_to_back;
    @(posedge clk);
    addr   <= 8'hA0;
    rd_stb <= 1'h1;
    @(posedge clk);
    addr   <= 8'h10;
    #1;
    `CHK("rdata first", exp_dw(1'h1), rdata)
    @(posedge clk);
    addr   <= 8'hA4;
    #1;
    `CHK("rdata unmapped", 32'h0, rdata)
    @(posedge clk);
    rd_stb <= 1'h0;
    #1;
    `CHK("rdata ctrl", 32'h0, rdata)
    @(posedge clk);
    #1;
    `CHK("rdata after burst", 32'h0, rdata)
  endtask : t_back_to_back
  task automatic t_restore;
    wr(8'hA0, 32'h0, 4'h8);
    pulse_pin(1'h0);
    `CHK("cold_wake bus rst", 1'h1, cold_wake)
    wr(8'hA4, 32'h00000100, 4'h2);
    rd(8'hA4, 32'h00000100);
    wr(8'hA0, 32'h0, 4'h8);
    pulse_pin(1'h0);
    `CHK("cold_wake held", 1'h0, cold_wake)
    `CHK("wake_en held", 1'h1, wake_en)
    rd(8'hA0, exp_dw(1'h0));
    pulse_pin(1'h1);
    `CHK("cold_wake glob", 1'h1, cold_wake)
    `CHK("wake_en glob", 1'h0, wake_en)
  endtask : t_restore
  // The ceiling is far above the fewer than a hundred cycles that the scenarios need.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    clk             = 1'h0;
    rst_b           = 1'h0;
    global_reset_in = 1'h0;
    bus_reset_in    = 1'h0;
    addr            = 8'h00;
    wdata           = 32'h0;
    byte_en         = 4'h0;
    wr_stb          = 1'h0;
    rd_stb          = 1'h0;
    n_mismatch      = 0;
    checks_done     = 0;
    cycles          = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    t_reset_values();
    t_write_mask();
    t_back_to_back();
    t_restore();
    tally_and_finish();
  end
endmodule : pci_pm_capability_regs_tb
